// file: verilog/acr_pkg.sv
/*
 * Constants for the converter setup word block: field positions,
 * reset value, word periods and chop dividers.
 * Assumes a crystal clock near 32.768 kHz sampled by a faster system clock.
 */
package acr_pkg;
	localparam int WORD_WIDTH = 24;
	localparam logic [23:0] SETUP_RESET = 24'h000040;
	localparam int LATCH_MSB = 23;
	localparam int LATCH_LSB = 20;
	localparam int UNUSED_HI_POS = 19;
	localparam int CHOP_RATE_POS = 18;
	localparam int UNUSED_LO_POS = 17;
	localparam int LOW_POWER_POS = 16;
	localparam int WORD_RATE_MSB = 15;
	localparam int WORD_RATE_LSB = 13;
	localparam int UNIPOLAR_POS = 12;
	localparam int RANGE_MSB = 11;
	localparam int RANGE_LSB = 9;
	localparam int PUMP_DISABLE_POS = 8;
	localparam int SOFT_RESET_POS = 7;
	localparam int RESET_FLAG_POS = 6;
	localparam int PORT_FLAG_POS = 5;
	localparam int POWER_SAVE_POS = 4;
	localparam int DONE_FLAG_POS = 3;
	localparam int CAL_MSB = 2;
	localparam int CAL_LSB = 0;
	// crystal cycles per output word, by word rate code
	localparam logic [13:0] WORD_CYCLES_0 = 14'd2182;
	localparam logic [13:0] WORD_CYCLES_1 = 14'd1090;
	localparam logic [13:0] WORD_CYCLES_2 = 14'd546;
	localparam logic [13:0] WORD_CYCLES_3 = 14'd266;
	localparam logic [13:0] WORD_CYCLES_4 = 14'd194;
	localparam logic [13:0] WORD_CYCLES_5 = 14'd162;
	localparam logic [13:0] WORD_CYCLES_6 = 14'd8722;
	localparam logic [13:0] WORD_CYCLES_7 = 14'd4362;
	// crystal edges (both) per chop half period: 256 Hz and 32768 Hz from 32768 Hz
	localparam logic [7:0] CHOP_SLOW_EDGES = 8'd128;
	localparam logic [7:0] CHOP_FAST_EDGES = 8'd1;
	// serial frame: one direction bit then the word
	localparam logic [4:0] FRAME_BITS = 5'd25;
endpackage

// file: verilog/acr_serial_port.sv
/*
 * Three-wire serial slave for the setup word: direction bit, then 24 bits
 * MSB first. Data sampled on rising serial clock, driven on falling.
 * Assumes all serial pins are asynchronous to clock_in and much slower.
 */
`timescale 1ns/1ns
module acr_serial_port (
	input wire logic clock_in, // system clock
	input wire logic sys_rst_in, // async reset, high
	input wire logic serial_clock_in, // host serial clock pin
	input wire logic serial_data_in, // host to device data pin
	input wire logic select_n_in, // frame select, low active
	input wire logic [23:0] read_word_in, // word to return on reads
	output logic write_strobe_out, // pulse: a write frame completed
	output logic [23:0] write_word_out, // word of the last write frame
	output logic read_done_out, // pulse: a read frame completed
	output logic serial_data_out // device to host data pin
);
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic prev_sclk;
	logic prev_sel_n;
	logic [4:0] bit_count;
	logic is_read;
	logic [23:0] shift_in;
	logic [23:0] snap;
	logic rise;
	logic fall;
	logic active;
	logic frame_start;
	logic frame_end;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			// idle levels: select high, clock and data low
			sync1 <= 3'h4;
			sync2 <= 3'h4;
			prev_sclk <= 1'b0;
			prev_sel_n <= 1'b1;
		end else begin
			sync1 <= {select_n_in, serial_data_in, serial_clock_in};
			sync2 <= sync1;
			prev_sclk <= sync2[0];
			prev_sel_n <= sync2[2];
		end
	end

	assign rise = sync2[0] & ~prev_sclk;
	assign fall = ~sync2[0] & prev_sclk;
	assign active = ~sync2[2];
	assign frame_start = ~sync2[2] & prev_sel_n;
	assign frame_end = sync2[2] & ~prev_sel_n;

	// shift in MSB first, direction bit leads
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bit_count <= 5'h00;
			is_read <= 1'b0;
			shift_in <= 24'h000000;
		end else if (frame_start) begin
			bit_count <= 5'h00;
			is_read <= 1'b0;
		end else if (active && rise) begin
			if (bit_count == 5'h00) begin
				is_read <= sync2[1];
			end else if (bit_count < acr_pkg::FRAME_BITS) begin
				shift_in <= {shift_in[22:0], sync2[1]};
			end
			// count past the frame length so overlong frames never look complete
			if (bit_count != 5'h1f) begin
				bit_count <= bit_count + 5'h01;
			end
		end
	end

	// read data leaves MSB first on falling edges
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			snap <= 24'h000000;
			serial_data_out <= 1'b0;
		end else if (!active) begin
			serial_data_out <= 1'b0;
		end else if (rise && bit_count == 5'h00) begin
			snap <= read_word_in;
		end else if (fall && is_read && bit_count != 5'h00 && bit_count < acr_pkg::FRAME_BITS) begin
			serial_data_out <= snap[23];
			snap <= {snap[22:0], 1'b0};
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			write_strobe_out <= 1'b0;
			read_done_out <= 1'b0;
			write_word_out <= 24'h000000;
		end else begin
			write_strobe_out <= frame_end && bit_count == acr_pkg::FRAME_BITS && !is_read;
			read_done_out <= frame_end && bit_count == acr_pkg::FRAME_BITS && is_read;
			if (frame_end && bit_count == acr_pkg::FRAME_BITS && !is_read) begin
				write_word_out <= shift_in;
			end
		end
	end

	chk_msb_first: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(active && rise && !frame_start && bit_count > 5'h00 && bit_count < acr_pkg::FRAME_BITS) |=>
		shift_in[0] == $past(sync2[1]))
		else $error("serial bit not shifted in at lsb end");
endmodule

// file: verilog/acr_setup_word.sv
/*
 * Converter setup word: the 24-bit configuration register, its mode outputs,
 * latch pins, chop clock, pump drive, word timing and completion flags.
 * Assumes the host keeps unused bits zero and the crystal runs near 32.768 kHz.
 */
// How it works
// - latch pins mirror top four setup bits
// - chop bit chooses 256 Hz or 32768 Hz
// - word rate field sets word period
// - gain field selects the input range
// - pump disable floats the pump drive pin
// - writing soft reset bit starts reset cycle
// - reset flag set on reset, cleared by read
// - port flag bit enables continuous output mode
// - power save bit picks standby or sleep
// - done flag set on finished cycle, read only
// - calibration field starts selected calibration
// - any reset loads 000040 hex
// - soft reset also sets the reset flag
`timescale 1ns/1ns
module acr_setup_word (
	input wire logic clock_in, // 20 MHz system clock
	input wire logic sys_rst_in, // async reset, high
	input wire logic crystal_input_clock_in, // oscillator clock, async
	input wire logic serial_clock_in, // host serial clock
	input wire logic serial_data_in, // host serial data in
	input wire logic select_n_in, // frame select, low active
	output logic serial_data_out, // serial data to host
	output logic [3:0] latch_output_bits_out, // general purpose latch pins
	output logic chop_clock_out, // amplifier chop clock
	output logic chop_rate_select_out, // chop rate mode level
	output logic low_power_select_out, // reduced power mode
	output logic unipolar_out, // unipolar measurement when high
	output logic [2:0] range_select_field_out, // input range code
	output logic range_valid_out, // range code is a used one
	output logic charge_pump_drive_pin_out, // pump drive level
	output logic charge_pump_drive_pin_oe_out, // pump drive enable
	output logic soft_reset_request_out, // pulse: reset cycle running
	output logic port_flag_mode_out, // continuous output mode
	output logic power_save_kind_out, // 0 standby, 1 sleep
	output logic oscillator_keep_out, // oscillator kept in power save
	output logic [2:0] calibration_select_field_out, // active calibration
	output logic word_tick_out // pulse: one word period ended
);
	logic [23:0] setup_word;
	logic write_strobe;
	logic [23:0] write_word;
	logic read_done;
	logic xtal_s1;
	logic xtal_s2;
	logic xtal_prev;
	logic xtal_edge;
	logic xtal_rise;
	logic [13:0] word_count;
	logic [13:0] word_period;
	logic [7:0] chop_count;
	logic [7:0] chop_limit;
	logic word_end;
	logic busy;
	logic soft_reset;

	acr_serial_port acr_serial_port_i (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.serial_clock_in(serial_clock_in),
		.serial_data_in(serial_data_in),
		.select_n_in(select_n_in),
		.read_word_in(setup_word),
		.write_strobe_out(write_strobe),
		.write_word_out(write_word),
		.read_done_out(read_done),
		.serial_data_out(serial_data_out)
	);

	function automatic logic [13:0] period_of(input logic [2:0] code);
		case (code)
			3'h0: period_of = acr_pkg::WORD_CYCLES_0;
			3'h1: period_of = acr_pkg::WORD_CYCLES_1;
			3'h2: period_of = acr_pkg::WORD_CYCLES_2;
			3'h3: period_of = acr_pkg::WORD_CYCLES_3;
			3'h4: period_of = acr_pkg::WORD_CYCLES_4;
			3'h5: period_of = acr_pkg::WORD_CYCLES_5;
			3'h6: period_of = acr_pkg::WORD_CYCLES_6;
			default: period_of = acr_pkg::WORD_CYCLES_7;
		endcase
	endfunction

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			xtal_s1 <= 1'b0;
			xtal_s2 <= 1'b0;
			xtal_prev <= 1'b0;
		end else begin
			xtal_s1 <= crystal_input_clock_in;
			xtal_s2 <= xtal_s1;
			xtal_prev <= xtal_s2;
		end
	end

	assign xtal_edge = xtal_s2 ^ xtal_prev;
	assign xtal_rise = xtal_s2 & ~xtal_prev;
	assign soft_reset = write_strobe && write_word[acr_pkg::SOFT_RESET_POS];
	assign word_period = period_of(setup_word[acr_pkg::WORD_RATE_MSB:acr_pkg::WORD_RATE_LSB]);
	assign busy = setup_word[acr_pkg::PORT_FLAG_POS] || setup_word[acr_pkg::CAL_MSB:acr_pkg::CAL_LSB] != 3'h0;
	assign word_end = xtal_rise && word_count == word_period - 14'd1;
	assign chop_limit = setup_word[acr_pkg::CHOP_RATE_POS] ? acr_pkg::CHOP_FAST_EDGES : acr_pkg::CHOP_SLOW_EDGES;

	// setup word storage; read-only and self-clearing bits kept by hardware
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			setup_word <= acr_pkg::SETUP_RESET;
		end else if (soft_reset) begin
			setup_word <= acr_pkg::SETUP_RESET;
		end else begin
			if (write_strobe) begin
				setup_word[23:7] <= write_word[23:7];
				setup_word[acr_pkg::UNUSED_HI_POS] <= 1'b0;
				setup_word[acr_pkg::UNUSED_LO_POS] <= 1'b0;
				setup_word[acr_pkg::SOFT_RESET_POS] <= 1'b0;
				setup_word[acr_pkg::PORT_FLAG_POS] <= write_word[acr_pkg::PORT_FLAG_POS];
				setup_word[acr_pkg::POWER_SAVE_POS] <= write_word[acr_pkg::POWER_SAVE_POS];
				setup_word[acr_pkg::CAL_MSB:acr_pkg::CAL_LSB] <= write_word[acr_pkg::CAL_MSB:acr_pkg::CAL_LSB];
			end else if (word_end && busy) begin
				setup_word[acr_pkg::CAL_MSB:acr_pkg::CAL_LSB] <= 3'h0;
			end
			if (read_done) begin
				setup_word[acr_pkg::RESET_FLAG_POS] <= 1'b0;
				setup_word[acr_pkg::DONE_FLAG_POS] <= 1'b0;
			end
			if (word_end && busy) begin
				setup_word[acr_pkg::DONE_FLAG_POS] <= 1'b1;
			end
		end
	end

	// word timer restarts on any write
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			word_count <= 14'h0000;
		end else if (write_strobe || !busy) begin
			word_count <= 14'h0000;
		end else if (xtal_rise) begin
			word_count <= word_end ? 14'h0000 : word_count + 14'h0001;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			chop_count <= 8'h00;
			chop_clock_out <= 1'b0;
		end else if (xtal_edge) begin
			if (chop_count >= chop_limit - 8'h01) begin
				chop_count <= 8'h00;
				chop_clock_out <= ~chop_clock_out;
			end else begin
				chop_count <= chop_count + 8'h01;
			end
		end
	end

	// registered mode outputs
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			latch_output_bits_out <= 4'h0;
			chop_rate_select_out <= 1'b0;
			low_power_select_out <= 1'b0;
			unipolar_out <= 1'b0;
			range_select_field_out <= 3'h0;
			range_valid_out <= 1'b1;
			charge_pump_drive_pin_out <= 1'b0;
			charge_pump_drive_pin_oe_out <= 1'b1;
			soft_reset_request_out <= 1'b0;
			port_flag_mode_out <= 1'b0;
			power_save_kind_out <= 1'b0;
			oscillator_keep_out <= 1'b1;
			calibration_select_field_out <= 3'h0;
			word_tick_out <= 1'b0;
		end else begin
			latch_output_bits_out <= setup_word[acr_pkg::LATCH_MSB:acr_pkg::LATCH_LSB];
			chop_rate_select_out <= setup_word[acr_pkg::CHOP_RATE_POS];
			low_power_select_out <= setup_word[acr_pkg::LOW_POWER_POS];
			unipolar_out <= setup_word[acr_pkg::UNIPOLAR_POS];
			range_select_field_out <= setup_word[acr_pkg::RANGE_MSB:acr_pkg::RANGE_LSB];
			range_valid_out <= setup_word[acr_pkg::RANGE_MSB:acr_pkg::RANGE_MSB - 1] != 2'h3;
			charge_pump_drive_pin_out <= xtal_s2;
			charge_pump_drive_pin_oe_out <= ~setup_word[acr_pkg::PUMP_DISABLE_POS];
			soft_reset_request_out <= soft_reset;
			port_flag_mode_out <= setup_word[acr_pkg::PORT_FLAG_POS];
			power_save_kind_out <= setup_word[acr_pkg::POWER_SAVE_POS];
			oscillator_keep_out <= ~setup_word[acr_pkg::POWER_SAVE_POS];
			calibration_select_field_out <= setup_word[acr_pkg::CAL_MSB:acr_pkg::CAL_LSB];
			word_tick_out <= word_end && busy;
		end
	end

	chk_latch_mirror: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		##1 latch_output_bits_out == $past(setup_word[23:20]))
		else $error("latch pins do not follow setup word");
	chk_unused_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		setup_word[19] == 1'b0 && setup_word[17] == 1'b0)
		else $error("unused setup bits not zero");
	chk_chop_fast: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(xtal_edge && setup_word[18] && chop_count == 8'h00) |=> chop_clock_out != $past(chop_clock_out))
		else $error("fast chop missed a crystal edge");
	chk_word_period: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		word_tick_out |-> $past(word_count) == $past(word_period) - 14'd1)
		else $error("word period length wrong");
	chk_range_follow: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		##1 range_select_field_out == $past(setup_word[11:9]))
		else $error("range output does not follow gain field");
	chk_pump_float: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		setup_word[8] ##1 setup_word[8] |-> !charge_pump_drive_pin_oe_out)
		else $error("pump drive enabled while disabled");
	chk_soft_reset: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		soft_reset |=> setup_word == acr_pkg::SETUP_RESET && soft_reset_request_out ##1 !soft_reset_request_out)
		else $error("soft reset did not reload setup word");
	chk_flag_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(read_done && !soft_reset) |=> !setup_word[6])
		else $error("reset flag not cleared by read");
	chk_done_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(word_end && busy && !soft_reset) |=> setup_word[3] && (setup_word[2:0] == 3'h0 || $past(write_strobe)))
		else $error("done flag or calibration end wrong");
	chk_sleep_kind: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		##1 oscillator_keep_out != power_save_kind_out)
		else $error("power save outputs inconsistent");
	chk_flag_sticky: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(setup_word[6] && !read_done) |=> setup_word[6])
		else $error("reset flag dropped without a read");
endmodule

// file: tb/acr_host_model.sv
/*
 * Host side of the three-wire serial link: frames of a direction bit and a
 * setup word, serial clock of 400 ns made from the system clock.
 * Assumes the caller runs one frame at a time.
 */
`timescale 1ns/1ns
module acr_host_model (
	input wire logic clock_in, // system clock
	input wire logic sdo_in, // device data out
	output logic sclk_out, // serial clock, low outside frames
	output logic sdi_out, // host data to device
	output logic sel_n_out // frame select, low active
);
	initial begin
		sclk_out = 1'b0;
		sdi_out = 1'b0;
		sel_n_out = 1'b1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	task automatic frame(input logic rd, input logic [23:0] wd, input int nbits, output logic [23:0] rw);
		logic [23:0] w;
		w = wd & ~24'h0a0000;
		rw = 24'h000000;
		sel_n_out = 1'b0;
		wait_n(4);
		for (int i = 0; i < nbits; i++) begin
			// direction then word msb first; unused data line toggles
			sdi_out = (i == 0) ? rd : ((rd || i > 24) ? ~sdi_out : w[24 - i]);
			wait_n(4);
			if (i > 0 && i < 25)
				rw[24 - i] = sdo_in;
			sclk_out = 1'b1;
			wait_n(4);
			sclk_out = 1'b0;
		end
		wait_n(4);
		sel_n_out = 1'b1;
		sdi_out = ~sdi_out;
		wait_n(16);
	endtask
endmodule

// file: tb/acr_setup_word_test.sv
/*
 * Self-checking bench for the setup word block, driven through the host model.
 * Assumes a 500 ns crystal clock so word periods stay short.
 */
`timescale 1ns/1ns
module acr_setup_word_test;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic xtal = 1'b0;
	logic sclk, sdi, sel_n, sdo, chop, chop_rate, low_pw, unip, valid, pump, oe_pin, sr, pf, ps, osc, tick;
	logic [3:0] latch;
	logic [2:0] rng, cal;
	logic [23:0] r;
	int failures = 0;
	int checked = 0;
	int sr_seen = 0;
	acr_host_model acr_host_model_i (.clock_in(clock_in), .sdo_in(sdo), .sclk_out(sclk), .sdi_out(sdi),
		.sel_n_out(sel_n));
	acr_setup_word acr_setup_word_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .crystal_input_clock_in(xtal),
		.serial_clock_in(sclk), .serial_data_in(sdi), .select_n_in(sel_n), .serial_data_out(sdo),
		.latch_output_bits_out(latch), .chop_clock_out(chop), .chop_rate_select_out(chop_rate),
		.low_power_select_out(low_pw), .unipolar_out(unip), .range_select_field_out(rng),
		.range_valid_out(valid), .charge_pump_drive_pin_out(pump), .charge_pump_drive_pin_oe_out(oe_pin),
		.soft_reset_request_out(sr), .port_flag_mode_out(pf), .power_save_kind_out(ps),
		.oscillator_keep_out(osc), .calibration_select_field_out(cal), .word_tick_out(tick));
	initial forever #25 clock_in = ~clock_in;
	initial begin
		forever begin
			repeat (5) @(negedge clock_in);
			xtal = ~xtal;
		end
	end
	always @(negedge clock_in) begin
		if (sr === 1'b1)
			sr_seen++;
	end
	task automatic end_sim;
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [23:0] w);
		logic [23:0] d;
		acr_host_model_i.frame(1'b0, w, 25, d);
	endtask
	task automatic rd(output logic [23:0] v);
		acr_host_model_i.frame(1'b1, 24'h000000, 25, v);
	endtask
	task automatic t_reset;
		rd(r);
		chk("word after reset", r, acr_pkg::SETUP_RESET);
		chk("pins after reset", {latch, oe_pin, osc, valid}, 24'h000007);
		rd(r);
		chk("flag after read", r, 24'h000000);
	endtask
	task automatic t_fields;
		wr(24'ha5bb10);
		chk("modes a", {latch, chop_rate, low_pw, unip}, 24'h000057);
		chk("modes b", {rng, valid, oe_pin, ps, osc, pf}, 24'h0000b4);
		rd(r);
		chk("readback", r, 24'ha5bb10);
		wr(24'h000020);
		chk("port flag", {pf, ps, osc}, 24'h000005);
		for (int g = 0; g < 8; g++) begin
			wr(24'(g << 9));
			chk("range", {rng, valid}, 24'(g * 2 + int'(g < 6)));
		end
		for (int c = 0; c < 8; c++) begin
			wr(24'(c));
			chk("cal code", cal, 24'(c));
		end
	endtask
	task automatic t_timer;
		int per[3] = '{162, 194, 266};
		int n;
		for (int k = 0; k < 3; k++) begin
			wr(24'(((5 - k) << 13) | 1));
			chk("cal running", cal, 24'h000001);
			n = 0;
			while (tick !== 1'b1 && n < 4000) begin
				@(negedge clock_in);
				n++;
			end
			chk("word period", 24'(n >= per[k] * 10 - 30 && n <= per[k] * 10 + 10), 24'h000001);
			rd(r);
			chk("done word", r, 24'(((5 - k) << 13) | 8));
		end
	endtask
	task automatic t_soft;
		int s0;
		s0 = sr_seen;
		wr(24'h0000a0);
		chk("reset pulse", 24'(sr_seen - s0), 24'h000001);
		rd(r);
		chk("after soft reset", r, acr_pkg::SETUP_RESET);
	endtask
	task automatic t_refused;
		wr(24'h300048);
		rd(r);
		chk("flag bits", r, 24'h300000);
		acr_host_model_i.frame(1'b0, 24'hc00000, 24, r);
		rd(r);
		chk("short frame", r, 24'h300000);
		acr_host_model_i.frame(1'b0, 24'hc00000, 26, r);
		rd(r);
		chk("long frame", r, 24'h300000);
	endtask
	task automatic t_hard;
		sys_rst_in = 1'b1;
		repeat (2) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge clock_in);
		chk("pins after hard reset", {latch, oe_pin, osc, valid}, 24'h000007);
		rd(r);
		chk("word after hard reset", r, acr_pkg::SETUP_RESET);
	endtask
	task automatic gap(output int n);
		logic v;
		n = 0;
		v = chop;
		while (chop === v && n < 2000) begin
			@(negedge clock_in);
			n++;
		end
		v = chop;
		n = 0;
		while (chop === v && n < 2000) begin
			@(negedge clock_in);
			n++;
		end
	endtask
	task automatic t_chop;
		int n;
		logic v;
		wr(24'h040000);
		gap(n);
		chk("chop fast", 24'(n), 24'd5);
		v = pump;
		repeat (5) @(negedge clock_in);
		chk("pump drive", {oe_pin, pump}, {1'b1, ~v});
		wr(24'h000000);
		gap(n);
		chk("chop slow", 24'(n), 24'd640);
	endtask
	initial begin
		repeat (16) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge clock_in);
		t_reset;
		t_fields;
		t_timer;
		t_soft;
		t_refused;
		t_hard;
		t_chop;
		end_sim;
	end
	initial begin
		#3000000;
		failures++;
		end_sim;
	end
endmodule
